// file: core/wewd_top.sv
// watchdog early-warning and clock-divider extension, top level
//
// Operation
// - Divider register bits 7:6 read zero and ignore writes.
// - With clear mode set, vector entry keeps the early flag; software clears it.
// - With clear mode zero and early enable set, vector execution clears the early flag.
// - First time-out sets the early flag when early-warning enable is set.
// - Writing one clears the early flag; writing zero leaves it.
// - Early enable plus early flag requests the shared watchdog interrupt.
// - Early interrupt needs both global interrupt enable and early enable.
// - Divide select codes 0..7 divide the oscillator by 1,3,..,15.
// - Divide select msb sits at bit 4, low bits at 1:0.
// - Prescale code gives 2048 divided cycles to first time-out, doubling per code.
// - Reset or interrupt time-out comes at twice the early interval.
// - The second time-out in interrupt mode sets the watchdog flag.
// - Prescale change needs change enable, which clears four cycles after set.
//
// Implementation choices: the AXI4-Lite interface to the registers and the placing of the registers.
`timescale 1ns/10ps
module wewd_top (
  // clock and reset
  input wire logic CLK_SYS,
  input wire logic SRST,
  input wire logic CE,
  // oscillator and core signals
  input wire logic OSC128_TICK,
  input wire logic CPU_GIE,
  input wire logic IRQ_ACK,
  input wire logic WDR_PULSE,
  // register bus
  input wewd_pkg::wewd_axil_req_t AXI_REQ,
  output wewd_pkg::wewd_axil_rsp_t AXI_RSP,
  // watchdog outputs
  output logic IRQ_REQ,
  output logic WD_RESET_REQ,
  output logic EARLY_WARN
);
  import wewd_pkg::*;

  typedef struct packed {
    logic clr_mode;
    logic [2:0] div_sel;
    logic eflag;
    logic een;
    logic tflag;
    logic ien;
    logic rsten;
    logic [3:0] wd_prescale_select;
    logic chg;
    logic [2:0] chg_cnt;
    logic [21:0] cnt;
    wewd_phase_t phase;
    logic irq;
    logic rst_req;
  } wewd_st_t;

  wewd_st_t q, d;

  logic wr_pulse;
  logic [7:0] wr_addr;
  logic [31:0] wr_data;
  logic [3:0] wr_strb;
  logic [7:0] rd_addr;
  logic [31:0] rd_data;
  logic wd_tick;
  logic div_wr;
  logic wd_wr;
  logic ce_wr;
  logic running;
  logic [21:0] cnt_n;
  logic hit_early;
  logic hit_second;

  // ==========================================================================
  // bus slave and divider
  wewd_axil i_wewd_axil (
    .clk_sys(CLK_SYS),
    .srst(SRST),
    .ce(CE),
    .req(AXI_REQ),
    .rsp(AXI_RSP),
    .wr_pulse(wr_pulse),
    .wr_addr(wr_addr),
    .wr_data(wr_data),
    .wr_strb(wr_strb),
    .rd_addr(rd_addr),
    .rd_data(rd_data)
  );

  wewd_div i_wewd_div (
    .clk_sys(CLK_SYS),
    .srst(SRST),
    .ce(CE),
    .osc_tick(OSC128_TICK),
    .div_sel(q.div_sel),
    .wd_tick(wd_tick)
  );

  // ==========================================================================
  // decode and read mux
  assign div_wr = wr_pulse && wr_strb[0] && (wr_addr == OFS_DIV_CTRL);
  assign wd_wr = wr_pulse && wr_strb[0] && (wr_addr == OFS_WD_CTRL);
  assign ce_wr = wd_wr && wr_data[WD_CE_BIT];
  assign running = q.een || q.ien || q.rsten;
  assign cnt_n = q.cnt + 22'h000001;
  assign hit_early = (cnt_n == wewd_early_len(q.wd_prescale_select));
  assign hit_second = (cnt_n == (wewd_early_len(q.wd_prescale_select) << 1));

  always_comb begin
    rd_data = 32'h00000000;
    if (rd_addr == OFS_DIV_CTRL) begin
      // upper bits stay zero from the default above
      rd_data[DIV_CLRMODE_BIT] = q.clr_mode;
      rd_data[DIV_MSB_BIT] = q.div_sel[2];
      rd_data[DIV_EFLAG_BIT] = q.eflag;
      rd_data[DIV_EEN_BIT] = q.een;
      rd_data[DIV_LSB_HI:DIV_LSB_LO] = q.div_sel[1:0];
    end else if (rd_addr == OFS_WD_CTRL) begin
      rd_data[WD_FLAG_BIT] = q.tflag;
      rd_data[WD_IEN_BIT] = q.ien;
      rd_data[WD_P3_BIT] = q.wd_prescale_select[3];
      rd_data[WD_CE_BIT] = q.chg;
      rd_data[WD_RSTEN_BIT] = q.rsten;
      rd_data[WD_PLO_HI:WD_PLO_LO] = q.wd_prescale_select[2:0];
    end
  end

  // ==========================================================================
  // next state
  always_comb begin
    d = q;
    d.rst_req = 1'b0;
    // change window countdown
    if (q.chg) begin
      if (q.chg_cnt == 3'h1) begin
        d.chg = 1'b0;
      end else begin
        d.chg_cnt = q.chg_cnt - 3'h1;
      end
    end
    // divider control write; bits 7:6 are never stored
    if (div_wr) begin
      d.clr_mode = wr_data[DIV_CLRMODE_BIT];
      d.div_sel = {wr_data[DIV_MSB_BIT], wr_data[DIV_LSB_HI:DIV_LSB_LO]};
      d.een = wr_data[DIV_EEN_BIT];
      if (wr_data[DIV_EFLAG_BIT]) begin
        d.eflag = 1'b0;
      end
    end
    // watchdog control write
    if (wd_wr) begin
      d.ien = wr_data[WD_IEN_BIT];
      if (wr_data[WD_FLAG_BIT]) begin
        d.tflag = 1'b0;
      end
      // prescale and reset-enable clear only inside an open window
      if (q.chg) begin
        d.wd_prescale_select = {wr_data[WD_P3_BIT], wr_data[WD_PLO_HI:WD_PLO_LO]};
        d.rsten = wr_data[WD_RSTEN_BIT];
      end else begin
        d.rsten = q.rsten || wr_data[WD_RSTEN_BIT];
      end
      if (ce_wr) begin
        d.chg = 1'b1;
        d.chg_cnt = CHG_HOLD;
      end
    end
    // vector execution
    if (IRQ_ACK) begin
      if (q.eflag && q.een && !q.clr_mode) begin
        d.eflag = 1'b0;
      end
      if (q.tflag && q.ien) begin
        d.tflag = 1'b0;
        // interrupt-and-reset mode falls back to reset mode
        if (q.rsten) begin
          d.ien = 1'b0;
        end
      end
    end
    // time-out counter; set events come last so they beat any clear
    if (WDR_PULSE || !running) begin
      d.cnt = 22'h000000;
      d.phase = PH_FIRST;
    end else if (wd_tick) begin
      d.cnt = cnt_n;
      case (q.phase)
        PH_FIRST: begin
          if (hit_early) begin
            d.phase = PH_SECOND;
            if (q.een) begin
              d.eflag = 1'b1;
            end
          end
        end
        PH_SECOND: begin
          if (hit_second) begin
            d.cnt = 22'h000000;
            d.phase = PH_FIRST;
            if (q.ien && !(q.tflag && q.rsten)) begin
              d.tflag = 1'b1;
            end else if (q.rsten) begin
              d.rst_req = 1'b1;
            end
          end
        end
        default: begin
          d.phase = PH_FIRST;
          d.cnt = 22'h000000;
        end
      endcase
    end
    d.irq = CPU_GIE && ((d.eflag && d.een) || (d.tflag && d.ien));
  end

  always_ff @(posedge CLK_SYS) begin
    if (SRST) begin
      q <= '0;
      q.phase <= PH_FIRST;
    end else if (CE) begin
      q <= d;
    end
  end

  assign IRQ_REQ = q.irq;
  assign WD_RESET_REQ = q.rst_req;
  assign EARLY_WARN = q.eflag;

  // ==========================================================================
  // checks
  default clocking cb @(posedge CLK_SYS);
  endclocking
  default disable iff (SRST);

  logic early_set;
  assign early_set = wd_tick && running && !WDR_PULSE && (q.phase == PH_FIRST) &&
                     hit_early && q.een;

  sequence chg_start_s;
    CE && ce_wr;
  endsequence

  sequence chg_quiet_s;
    (CE && !wr_pulse)[*4];
  endsequence

  rsvd_read_a: assert property ((rd_addr == OFS_DIV_CTRL) |->
    rd_data[DIV_RSVD_HI:DIV_RSVD_LO] == 2'h0)
    else $error("reserved divider bits read nonzero");

  div_field_a: assert property (CE && div_wr |=>
    q.div_sel == {$past(wr_data[DIV_MSB_BIT]), $past(wr_data[DIV_LSB_HI:DIV_LSB_LO])})
    else $error("divide select not taken from bits 4 and 1:0");

  eflag_set_a: assert property (CE && early_set |=> q.eflag)
    else $error("early flag not set at first time-out");

  eflag_w1c_a: assert property (CE && div_wr && wr_data[DIV_EFLAG_BIT] && !early_set
    |=> !q.eflag)
    else $error("early flag not cleared by writing one");

  eflag_keep_a: assert property (CE && q.eflag && IRQ_ACK && q.clr_mode &&
    !(div_wr && wr_data[DIV_EFLAG_BIT]) |=> q.eflag)
    else $error("early flag cleared by vector in software-clear mode");

  eflag_auto_a: assert property (CE && q.eflag && q.een && IRQ_ACK && !q.clr_mode &&
    !early_set |=> !q.eflag)
    else $error("early flag not cleared by vector");

  irq_early_a: assert property (CE && CPU_GIE && early_set && !div_wr |=> IRQ_REQ)
    else $error("early warning did not request interrupt");

  irq_gate_a: assert property (CE && !CPU_GIE |=> !IRQ_REQ)
    else $error("interrupt requested with global enable low");

  second_reset_a: assert property (CE && wd_tick && running && !WDR_PULSE &&
    (q.phase == PH_SECOND) && hit_second && !q.ien && q.rsten |=> WD_RESET_REQ)
    else $error("no reset at second time-out");

  tflag_set_a: assert property (CE && wd_tick && running && !WDR_PULSE &&
    (q.phase == PH_SECOND) && hit_second && q.ien && !q.tflag |=> q.tflag)
    else $error("watchdog flag not set at second time-out");

  chg_window_a: assert property (chg_start_s ##1 chg_quiet_s |=> !q.chg)
    else $error("change enable not cleared after four cycles");

  chg_open_a: assert property (chg_start_s |=> q.chg ##1 q.chg)
    else $error("change enable closed too early");

endmodule : wewd_top

// file: core/wewd_pkg.sv
// shared constants, carriers and helpers for the watchdog early-warning divider
package wewd_pkg;

  // ==========================================================================
  // bus carriers
  typedef struct packed {
    logic awvalid;
    logic [7:0] awaddr;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [7:0] araddr;
    logic rready;
  } wewd_axil_req_t;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } wewd_axil_rsp_t;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ==========================================================================
  // register map
  localparam logic [7:0] OFS_DIV_CTRL = 8'h00;
  localparam logic [7:0] OFS_WD_CTRL = 8'h04;

  // divider control fields
  localparam int DIV_CLRMODE_BIT = 5;
  localparam int DIV_MSB_BIT = 4;
  localparam int DIV_EFLAG_BIT = 3;
  localparam int DIV_EEN_BIT = 2;
  localparam int DIV_LSB_HI = 1;
  localparam int DIV_LSB_LO = 0;
  localparam int DIV_RSVD_HI = 7;
  localparam int DIV_RSVD_LO = 6;

  // watchdog control fields
  localparam int WD_FLAG_BIT = 7;
  localparam int WD_IEN_BIT = 6;
  localparam int WD_P3_BIT = 5;
  localparam int WD_CE_BIT = 4;
  localparam int WD_RSTEN_BIT = 3;
  localparam int WD_PLO_HI = 2;
  localparam int WD_PLO_LO = 0;

  // ==========================================================================
  // timing
  localparam logic [2:0] CHG_HOLD = 3'h4;
  localparam logic [21:0] TO_BASE = 22'h000800;
  localparam logic [3:0] WDP_MAX = 4'h9;

  typedef enum logic [1:0] {
    PH_FIRST = 2'b01,
    PH_SECOND = 2'b10
  } wewd_phase_t;

  // reserved prescale codes clamp to the longest interval
  function automatic logic [21:0] wewd_early_len(input logic [3:0] p);
    logic [3:0] c;
    c = (p > WDP_MAX) ? WDP_MAX : p;
    return TO_BASE << c;
  endfunction : wewd_early_len

  function automatic logic [3:0] wewd_div_ratio(input logic [2:0] s);
    return {s, 1'b1};
  endfunction : wewd_div_ratio

  function automatic logic wewd_mapped(input logic [7:0] a);
    return (a == OFS_DIV_CTRL) || (a == OFS_WD_CTRL);
  endfunction : wewd_mapped

endpackage : wewd_pkg

// file: core/wewd_div.sv
// odd-ratio divider of the 128 kHz oscillator tick
`timescale 1ns/10ps
module wewd_div (
  // clock and reset
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic ce,
  // oscillator and select
  input wire logic osc_tick,
  input wire logic [2:0] div_sel,
  // divided tick
  output logic wd_tick
);
  import wewd_pkg::*;

  typedef struct packed {
    logic [3:0] cnt;
    logic tick;
  } wewd_div_st_t;

  wewd_div_st_t q, d;

  // ==========================================================================
  // next state
  always_comb begin
    d = q;
    d.tick = 1'b0;
    if (osc_tick) begin
      // a shrinking ratio mid-count wraps at once instead of overrunning
      if (q.cnt + 4'h1 >= wewd_div_ratio(div_sel)) begin
        d.cnt = 4'h0;
        d.tick = 1'b1;
      end else begin
        d.cnt = q.cnt + 4'h1;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      q <= '0;
    end else if (ce) begin
      q <= d;
    end
  end

  assign wd_tick = q.tick;

  div_period_a: assert property (@(posedge clk_sys) disable iff (srst)
    ce && osc_tick && (q.cnt + 4'h1 >= wewd_div_ratio(div_sel)) |=> wd_tick)
    else $error("divided tick missing at ratio end");

endmodule : wewd_div

// file: core/wewd_axil.sv
// AXI4-Lite slave front end for the watchdog registers
`timescale 1ns/10ps
module wewd_axil (
  // clock and reset
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic ce,
  // bus
  input wewd_pkg::wewd_axil_req_t req,
  output wewd_pkg::wewd_axil_rsp_t rsp,
  // register side
  output logic wr_pulse,
  output logic [7:0] wr_addr,
  output logic [31:0] wr_data,
  output logic [3:0] wr_strb,
  output logic [7:0] rd_addr,
  input wire logic [31:0] rd_data
);
  import wewd_pkg::*;

  typedef struct packed {
    wewd_axil_rsp_t rsp;
    logic aw_have;
    logic w_have;
    logic wr;
    logic [7:0] addr;
    logic [31:0] data;
    logic [3:0] strb;
  } wewd_axil_st_t;

  wewd_axil_st_t q, d;

  assign rd_addr = req.araddr;

  // ==========================================================================
  // next state
  always_comb begin
    d = q;
    d.wr = 1'b0;
    if (req.awvalid && q.rsp.awready) begin
      d.aw_have = 1'b1;
      d.addr = req.awaddr;
    end
    if (req.wvalid && q.rsp.wready) begin
      d.w_have = 1'b1;
      d.data = req.wdata;
      d.strb = req.wstrb;
    end
    if (q.rsp.bvalid && req.bready) begin
      d.rsp.bvalid = 1'b0;
    end
    // one write at a time: both halves held until the response is gone
    if (q.aw_have && q.w_have && !q.rsp.bvalid) begin
      d.wr = wewd_mapped(q.addr);
      d.rsp.bvalid = 1'b1;
      d.rsp.bresp = wewd_mapped(q.addr) ? RESP_OKAY : RESP_SLVERR;
      d.aw_have = 1'b0;
      d.w_have = 1'b0;
    end
    d.rsp.awready = !d.aw_have && !d.rsp.bvalid;
    d.rsp.wready = !d.w_have && !d.rsp.bvalid;
    if (q.rsp.rvalid && req.rready) begin
      d.rsp.rvalid = 1'b0;
    end
    if (req.arvalid && q.rsp.arready) begin
      d.rsp.rvalid = 1'b1;
      d.rsp.rdata = wewd_mapped(req.araddr) ? rd_data : 32'h00000000;
      d.rsp.rresp = wewd_mapped(req.araddr) ? RESP_OKAY : RESP_SLVERR;
    end
    d.rsp.arready = !d.rsp.rvalid;
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      q <= '0;
    end else if (ce) begin
      q <= d;
    end
  end

  assign rsp = q.rsp;
  assign wr_pulse = q.wr;
  assign wr_addr = q.addr;
  assign wr_data = q.data;
  assign wr_strb = q.strb;

endmodule : wewd_axil

// file: tb/watchdog_early_warning_divider_bench.sv
// self-checking bench for the watchdog early-warning divider
`timescale 1ns/10ps
module watchdog_early_warning_divider_bench;
  import wewd_pkg::*;

  // ==========================================================================
  // clock, reset, stimulus
  logic clk_sys = 1'b0;
  logic srst = 1'b1;
  logic osc = 1'b0;
  logic gie = 1'b0;
  logic ack = 1'b0;
  logic wdr = 1'b0;
  logic ce = 1'b1;
  wewd_axil_req_t axi_req = '0;
  wewd_axil_rsp_t axi_rsp;
  logic irq_req;
  logic rst_req;
  logic early_warn;
  logic [2:0] outs;
  logic [33:0] rq[$];
  logic [1:0] bq[$];
  int num_errors = 0;
  int n_checks = 0;
  int cycles = 0;
  int cnt;
  logic [7:0] v;

  initial begin
    forever #25 clk_sys = ~clk_sys;
  end

  wewd_top i_wewd_top (
    .CLK_SYS(clk_sys),
    .SRST(srst),
    .CE(ce),
    .OSC128_TICK(osc),
    .CPU_GIE(gie),
    .IRQ_ACK(ack),
    .WDR_PULSE(wdr),
    .AXI_REQ(axi_req),
    .AXI_RSP(axi_rsp),
    .IRQ_REQ(irq_req),
    .WD_RESET_REQ(rst_req),
    .EARLY_WARN(early_warn)
  );

  // one line per watched output, picked by run_to
  assign outs = {rst_req, irq_req, early_warn};

  // ==========================================================================
  // checking and closing
  task automatic check(input logic [33:0] seen, input logic [33:0] exp);
    n_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : give_verdict

  // ceiling covers about 66k cycles of timed runs plus bus traffic
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 90000) begin
      num_errors++;
      give_verdict();
    end
  end

  // monitor: each bus answer is matched against the oldest note
  always @(posedge clk_sys) begin
    if (axi_rsp.rvalid && axi_req.rready) begin
      if (rq.size() == 0) check(34'h0, 34'h3_0000_0000);
      else check({axi_rsp.rresp, axi_rsp.rdata}, rq.pop_front());
    end
    if (axi_rsp.bvalid && axi_req.bready) begin
      if (bq.size() == 0) check(34'h0, 34'h3_0000_0000);
      else check({32'h0, axi_rsp.bresp}, {32'h0, bq.pop_front()});
    end
  end

  // ==========================================================================
  // bus master
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] br);
    logic done;
    done = 1'b0;
    bq.push_back(br);
    @(posedge clk_sys);
    axi_req.awvalid <= 1'b1;
    axi_req.awaddr <= a;
    axi_req.wvalid <= 1'b1;
    axi_req.wdata <= {24'h0, d};
    axi_req.wstrb <= 4'hF;
    axi_req.bready <= 1'b1;
    while (!done) begin
      @(posedge clk_sys);
      if (axi_req.awvalid && axi_rsp.awready) axi_req.awvalid <= 1'b0;
      if (axi_req.wvalid && axi_rsp.wready) axi_req.wvalid <= 1'b0;
      if (axi_req.bready && axi_rsp.bvalid) begin
        axi_req.bready <= 1'b0;
        done = 1'b1;
      end
    end
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] d, input logic [1:0] rr);
    logic done;
    done = 1'b0;
    rq.push_back({rr, 24'h0, d});
    @(posedge clk_sys);
    axi_req.arvalid <= 1'b1;
    axi_req.araddr <= a;
    axi_req.rready <= 1'b1;
    while (!done) begin
      @(posedge clk_sys);
      if (axi_req.arvalid && axi_rsp.arready) axi_req.arvalid <= 1'b0;
      if (axi_req.rready && axi_rsp.rvalid) begin
        axi_req.rready <= 1'b0;
        done = 1'b1;
      end
    end
  endtask : rd

  // restart the timer, tick every cycle, count until the chosen output rises
  // sel 0 early warning, 1 interrupt request, 2 reset request
  task automatic run_to(input logic [1:0] sel, input int n, output int c);
    c = 0;
    @(posedge clk_sys);
    wdr <= 1'b1;
    osc <= 1'b1;
    @(posedge clk_sys);
    wdr <= 1'b0;
    while (outs[sel] !== 1'b1 && c < n + 64) begin
      @(posedge clk_sys);
      c++;
    end
    osc <= 1'b0;
  endtask : run_to

  task automatic pulse_ack();
    @(posedge clk_sys);
    ack <= 1'b1;
    @(posedge clk_sys);
    ack <= 1'b0;
    repeat (3) @(posedge clk_sys);
  endtask : pulse_ack

  // ==========================================================================
  // tests
  initial begin
    logic [2:0] codes[3];
    int n;
    codes = '{3'h0, 3'h2, 3'h7};
    void'($urandom(32'hA8DCA2C6));
    repeat (10) @(posedge clk_sys);
    srst <= 1'b0;

    rd(OFS_DIV_CTRL, 8'h00, RESP_OKAY);
    rd(OFS_WD_CTRL, 8'h00, RESP_OKAY);
    rd(8'h08, 8'h00, RESP_SLVERR);
    wr(8'h08, 8'hFF, RESP_SLVERR);
    $display("test reset and map done");

    // flag stays clear with the oscillator idle, so only the stored bits return
    for (int i = 0; i < 8; i++) begin
      v = 8'($urandom());
      wr(OFS_DIV_CTRL, v, RESP_OKAY);
      rd(OFS_DIV_CTRL, v & 8'h37, RESP_OKAY);
    end
    $display("test divider fields done");

    gie <= 1'b1;
    foreach (codes[k]) begin
      n = 2048 * (2 * codes[k] + 1);
      wr(OFS_DIV_CTRL, {3'h0, codes[k][2], 2'h1, codes[k][1:0]}, RESP_OKAY);
      run_to(2'd0, n, cnt);
      check({33'h0, cnt >= n - 4 && cnt <= n + 2 * codes[k] + 8}, 34'h1);
      @(posedge clk_sys);
      check({33'h0, irq_req}, 34'h1);
      // vector seen while frozen: the flag must survive until the clock runs again
      ce <= 1'b0;
      pulse_ack();
      check({33'h0, early_warn}, 34'h1);
      ce <= 1'b1;
      pulse_ack();
      check({33'h0, early_warn}, 34'h0);
    end
    $display("test early warning timing done");

    gie <= 1'b0;
    wr(OFS_DIV_CTRL, 8'h24, RESP_OKAY);
    run_to(2'd0, 2048, cnt);
    @(posedge clk_sys);
    check({33'h0, irq_req}, 34'h0);
    pulse_ack();
    check({33'h0, early_warn}, 34'h1);
    gie <= 1'b1;
    repeat (3) @(posedge clk_sys);
    check({33'h0, irq_req}, 34'h1);
    wr(OFS_DIV_CTRL, 8'h20, RESP_OKAY);
    rd(OFS_DIV_CTRL, 8'h28, RESP_OKAY);
    wr(OFS_DIV_CTRL, 8'h28, RESP_OKAY);
    rd(OFS_DIV_CTRL, 8'h20, RESP_OKAY);
    $display("test clear mode done");

    wr(OFS_DIV_CTRL, 8'h00, RESP_OKAY);
    wr(OFS_WD_CTRL, 8'h40, RESP_OKAY);
    run_to(2'd1, 4096, cnt);
    check({33'h0, cnt >= 4092 && cnt <= 4104}, 34'h1);
    rd(OFS_WD_CTRL, 8'hC0, RESP_OKAY);
    pulse_ack();
    rd(OFS_WD_CTRL, 8'h40, RESP_OKAY);
    wr(OFS_WD_CTRL, 8'h00, RESP_OKAY);
    $display("test second time-out done");

    // the window is only a few cycles, so the two writes go back to back
    wr(OFS_WD_CTRL, 8'h10, RESP_OKAY);
    wr(OFS_WD_CTRL, 8'h01, RESP_OKAY);
    rd(OFS_WD_CTRL, 8'h01, RESP_OKAY);
    wr(OFS_WD_CTRL, 8'h02, RESP_OKAY);
    rd(OFS_WD_CTRL, 8'h01, RESP_OKAY);
    wr(OFS_WD_CTRL, 8'h11, RESP_OKAY);
    repeat (10) @(posedge clk_sys);
    rd(OFS_WD_CTRL, 8'h01, RESP_OKAY);
    $display("test change window done");

    // prescale code 1 now: early at 4096 ticks, second time-out at 8192
    wr(OFS_WD_CTRL, 8'h08, RESP_OKAY);
    run_to(2'd2, 8192, cnt);
    check({33'h0, cnt >= 8188 && cnt <= 8200}, 34'h1);
    // interrupt-and-reset mode: the vector drops the interrupt enable
    wr(OFS_WD_CTRL, 8'h48, RESP_OKAY);
    run_to(2'd1, 8192, cnt);
    check({33'h0, cnt >= 8188 && cnt <= 8200}, 34'h1);
    rd(OFS_WD_CTRL, 8'hC9, RESP_OKAY);
    pulse_ack();
    rd(OFS_WD_CTRL, 8'h09, RESP_OKAY);
    $display("test reset modes done");

    repeat (4) @(posedge clk_sys);
    check({32'h0, rq.size() == 0, bq.size() == 0}, 34'h3);
    give_verdict();
  end

endmodule : watchdog_early_warning_divider_bench
